// >>> hw/ucf_frame.sv
// Host-port frame engine: receiver, flush break, frame decode, response sender
`timescale 1ns/10ps
`include "ucf_params.svh"
// ----------------------------------------
// Summary of operation
// - While transmitting, ignore receive bytes except break
// - Break accepted any time, never forwarded
// - Break resets receiver; next byte starts frame
// - Break sets flush and stop-error flags
// - Wake ping resets receiver, sets flags
// - Break during response discards it, sets debug
// - Host initiates; device sends only after read
// - Stack commands act only with stack role
// - Broadcast commands act on this device too
// - Reverse broadcast propagates opposite direction
// - Header, optional node, address, data, check
// - Header bit 7 marks command or response
// - Header bits 6..4 select request type
// - Reserved request does nothing, sets invalid flag
// - Bit 3 ignored; bits 2..0 length minus one
// - Node byte only in single-device commands
// - Single commands match forward or reverse address per direction bit
// - Bytes are 8-N-1; zero stop sets flag
// - Register address sent high byte first
// - Check code x16+x15+x2+1, bad frame dropped
// - Bits sent LSB first, check follows order
// ----------------------------------------
module ucf_frame (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Host UART pins
	input wire logic rx_i,
	output logic tx_o,
	// Power-state events
	input wire logic sleep_i,
	input wire logic wake_ping_i,
	// Command towards the register core
	output logic cmd_valid_o,
	output ucf_pkg::ucf_cmd_s cmd_o,
	// Response bytes from the register core
	input wire ucf_pkg::ucf_rsp_s rsp_i,
	output logic rsp_ready_o,
	output logic rsp_abort_o,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	localparam logic [7:0] BIT_M1 = 8'(`UCF_BIT_CYC - 1);
	localparam logic [7:0] HALF_M1 = 8'(`UCF_HALF_CYC - 1);
	localparam logic [10:0] BRK_M1 = 11'(`UCF_BRK_CYC - 1);

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT_HIGH} ucf_rx_e;
	typedef enum {F_HDR, F_NODE, F_RA1, F_RA2, F_DATA, F_CRC1, F_CRC2} ucf_frm_e;
	typedef enum {T_IDLE, T_WAIT, T_SHIFT} ucf_tx_e;

	// One LSB-first step of the reflected check code
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `UCF_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	logic [1:0] ctrl_q;
	logic [5:0] fwd_addr_q, rev_addr_q;
	logic [5:0] flags_q, flag_set, flag_clr;
	logic [10:0] low_q;
	logic flush_p, flush_any;
	ucf_rx_e rx_st;
	logic [7:0] rx_cnt_q, rx_sr_q, rxb_q;
	logic [2:0] rx_idx_q;
	logic rxb_v_q, stop_err_p;
	ucf_frm_e frm_st;
	logic [7:0] hdr_q, node_q, ra_hi_q, ra_lo_q;
	logic [7:0] dat_mem [0:7];
	logic [2:0] dcnt_q;
	logic [15:0] crc_q, crc_nx;
	logic last_b, good, single, stack, rsvd, node_ok, act, rd;
	ucf_tx_e tx_st;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_bit_q;
	logic [7:0] tx_cnt_q;
	logic tx_last_q, tx_started_q, tx_busy;
	logic wb_req, wb_wr;
	logic [7:0] last_hdr_q;

	// ----------------------------------------
	// Break detection
	// ----------------------------------------
	// Low time runs in every transmit state so a break is never masked
	always_ff @(posedge clock_i) begin
		if (reset_i || rx_i) begin
			low_q <= '0;
		end else if (low_q != BRK_M1 + 11'h001) begin
			low_q <= low_q + 11'h001;
		end
	end

	assign flush_p = !rx_i && (low_q == BRK_M1);
	assign flush_any = flush_p || wake_ping_i;

	// ----------------------------------------
	// Byte receiver, 8-N-1, LSB first
	// ----------------------------------------
	// A start edge is only taken while nothing is being sent
	always_ff @(posedge clock_i) begin
		rxb_v_q <= 1'b0;
		stop_err_p <= 1'b0;
		if (reset_i) begin
			rx_st <= RX_WAIT_HIGH;
			rx_cnt_q <= '0;
			rx_idx_q <= '0;
			rx_sr_q <= '0;
			rxb_q <= '0;
		end else if (flush_any) begin
			rx_st <= RX_WAIT_HIGH;
		end else begin
			unique case (rx_st)
				RX_IDLE: begin
					if (!rx_i && !tx_busy) begin
						rx_st <= RX_START;
						rx_cnt_q <= HALF_M1;
					end
				end
				RX_START: begin
					if (rx_cnt_q != 8'h00) begin
						rx_cnt_q <= rx_cnt_q - 8'h01;
					end else begin
						rx_st <= rx_i ? RX_IDLE : RX_DATA;
						rx_cnt_q <= BIT_M1;
						rx_idx_q <= '0;
					end
				end
				RX_DATA: begin
					if (rx_cnt_q != 8'h00) begin
						rx_cnt_q <= rx_cnt_q - 8'h01;
					end else begin
						rx_sr_q <= {rx_i, rx_sr_q[7:1]};
						rx_idx_q <= rx_idx_q + 3'h1;
						rx_cnt_q <= BIT_M1;
						if (rx_idx_q == 3'h7) begin
							rx_st <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_cnt_q != 8'h00) begin
						rx_cnt_q <= rx_cnt_q - 8'h01;
					end else if (rx_i) begin
						rx_st <= RX_IDLE;
						rxb_v_q <= 1'b1;
						rxb_q <= rx_sr_q;
					end else begin
						// A zero stop bit drops the byte and waits out the low line
						rx_st <= RX_WAIT_HIGH;
						stop_err_p <= 1'b1;
					end
				end
				RX_WAIT_HIGH: begin
					if (rx_i) begin
						rx_st <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	assign crc_nx = crc_step(crc_q, rxb_q);
	assign last_b = rxb_v_q && (frm_st == F_CRC2);
	assign good = last_b && (crc_nx == 16'h0000);
	assign single = (hdr_q[6:4] == `UCF_REQ_SRD) || (hdr_q[6:4] == `UCF_REQ_SWR);
	assign stack = (hdr_q[6:4] == `UCF_REQ_KRD) || (hdr_q[6:4] == `UCF_REQ_KWR);
	assign rsvd = (hdr_q[6:4] == `UCF_REQ_RSV);
	// Only the three read kinds open a response; reverse broadcast is a write
	assign rd = (hdr_q[6:4] == `UCF_REQ_SRD) || (hdr_q[6:4] == `UCF_REQ_KRD) || (hdr_q[6:4] == `UCF_REQ_BRD);
	// Only the low six bits name the node; the top two are not compared
	assign node_ok = node_q[5:0] == (ctrl_q[`UCF_CTRL_DIR] ? rev_addr_q : fwd_addr_q);
	// Broadcast kinds fall through and always act
	assign act = good && !rsvd && (single ? node_ok : (stack ? ctrl_q[`UCF_CTRL_STACK] : 1'b1));

	// Field sequencer; every frame restarts at the header after a break
	always_ff @(posedge clock_i) begin
		if (reset_i || flush_any) begin
			frm_st <= F_HDR;
			crc_q <= `UCF_CRC_INIT;
			dcnt_q <= '0;
		end else if (rxb_v_q) begin
			crc_q <= crc_nx;
			unique case (frm_st)
				F_HDR: begin
					crc_q <= crc_step(`UCF_CRC_INIT, rxb_q);
					// Bit 3 of the header is never looked at
					if (rxb_q[`UCF_HDR_CMD_BIT]) begin
						hdr_q <= rxb_q;
						frm_st <= (rxb_q[6:5] == 2'b00) ? F_NODE : F_RA1;
					end
				end
				F_NODE: frm_st <= F_RA1;
				F_RA1: frm_st <= F_RA2;
				F_RA2: begin
					frm_st <= F_DATA;
					dcnt_q <= '0;
				end
				F_DATA: begin
					dcnt_q <= dcnt_q + 3'h1;
					if (dcnt_q == hdr_q[2:0]) begin
						frm_st <= F_CRC1;
					end
				end
				F_CRC1: frm_st <= F_CRC2;
				F_CRC2: frm_st <= F_HDR;
			endcase
		end
	end

	// Field capture, high address byte first
	always_ff @(posedge clock_i) begin
		if (rxb_v_q) begin
			if (frm_st == F_NODE) begin
				node_q <= rxb_q;
			end
			if (frm_st == F_RA1) begin
				ra_hi_q <= rxb_q;
			end
			if (frm_st == F_RA2) begin
				ra_lo_q <= rxb_q;
			end
			if (frm_st == F_DATA) begin
				dat_mem[dcnt_q] <= rxb_q;
			end
		end
	end

	// Command out; a frame with a bad check never reaches here
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cmd_valid_o <= 1'b0;
			cmd_o <= '0;
			last_hdr_q <= '0;
		end else begin
			cmd_valid_o <= act;
			if (act) begin
				last_hdr_q <= hdr_q;
				cmd_o.req <= ucf_pkg::ucf_req_e'(hdr_q[6:4]);
				cmd_o.is_read <= rd;
				cmd_o.prop_dir <= ctrl_q[`UCF_CTRL_DIR] ^ (hdr_q[6:4] == `UCF_REQ_RWR);
				cmd_o.reg_addr <= {ra_hi_q, ra_lo_q};
				cmd_o.len_m1 <= hdr_q[2:0];
				for (int i = 0; i < 8; i++) begin
					cmd_o.data[8 * i +: 8] <= dat_mem[i];
				end
			end
		end
	end

	// ----------------------------------------
	// Response sender
	// ----------------------------------------
	assign tx_busy = (tx_st != T_IDLE);
	assign rsp_ready_o = (tx_st == T_WAIT);
	assign tx_o = tx_sh_q[0];

	// A read opens the only window in which bytes go out
	always_ff @(posedge clock_i) begin
		rsp_abort_o <= 1'b0;
		if (reset_i) begin
			tx_st <= T_IDLE;
			tx_sh_q <= 10'h3ff;
			tx_bit_q <= '0;
			tx_cnt_q <= '0;
			tx_last_q <= 1'b0;
			tx_started_q <= 1'b0;
		end else if (flush_any) begin
			// Cutting mid-byte is accepted: the host asked to abandon it
			tx_st <= T_IDLE;
			tx_sh_q <= 10'h3ff;
			rsp_abort_o <= tx_busy;
		end else begin
			unique case (tx_st)
				T_IDLE: begin
					tx_started_q <= 1'b0;
					if (act && rd) begin
						tx_st <= T_WAIT;
					end
				end
				T_WAIT: begin
					if (rsp_i.valid) begin
						tx_sh_q <= {1'b1, rsp_i.data, 1'b0};
						tx_last_q <= rsp_i.last;
						tx_started_q <= 1'b1;
						tx_bit_q <= '0;
						tx_cnt_q <= BIT_M1;
						tx_st <= T_SHIFT;
					end
				end
				T_SHIFT: begin
					if (tx_cnt_q != 8'h00) begin
						tx_cnt_q <= tx_cnt_q - 8'h01;
					end else if (tx_bit_q == 4'h9) begin
						tx_st <= tx_last_q ? T_IDLE : T_WAIT;
					end else begin
						tx_sh_q <= {1'b1, tx_sh_q[9:1]};
						tx_bit_q <= tx_bit_q + 4'h1;
						tx_cnt_q <= BIT_M1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Status flags and Wishbone slave
	// ----------------------------------------
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land on the edge at which the master sees ack, while it still holds the request
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	// Flag sources; a set in the clearing cycle wins
	always_comb begin
		flag_set = '0;
		flag_set[`UCF_FL_FLUSH] = flush_any;
		flag_set[`UCF_FL_STOP] = flush_p || stop_err_p || (wake_ping_i && !sleep_i);
		flag_set[`UCF_FL_CRC] = last_b && !good;
		flag_set[`UCF_FL_INVAL] = good && rsvd;
		flag_set[`UCF_FL_TRWAIT] = flush_any && tx_busy && !tx_started_q;
		flag_set[`UCF_FL_TRSOFI] = flush_any && tx_busy && tx_started_q;
		flag_clr = (wb_wr && wb_adr_i == `UCF_OFS_FLAGS && wb_sel_i[0]) ? wb_dat_i[5:0] : 6'h00;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			flags_q <= `UCF_FLAGS_RST;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	// Writable configuration
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ctrl_q <= `UCF_CTRL_RST;
			fwd_addr_q <= `UCF_NODE_RST;
			rev_addr_q <= `UCF_NODE_RST;
		end else if (wb_wr) begin
			if (wb_adr_i == `UCF_OFS_CTRL && wb_sel_i[0]) begin
				ctrl_q <= wb_dat_i[1:0];
			end
			if (wb_adr_i == `UCF_OFS_ADDR && wb_sel_i[0]) begin
				fwd_addr_q <= wb_dat_i[5:0];
			end
			if (wb_adr_i == `UCF_OFS_ADDR && wb_sel_i[1]) begin
				rev_addr_q <= wb_dat_i[`UCF_ADDR_REV_LSB +: 6];
			end
		end
	end

	// One wait state; unmapped reads give zero, unmapped writes are dropped
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			unique case (wb_adr_i)
				`UCF_OFS_CTRL: wb_dat_o <= {30'h0, ctrl_q};
				`UCF_OFS_ADDR: wb_dat_o <= {18'h0, rev_addr_q, 2'h0, fwd_addr_q};
				`UCF_OFS_FLAGS: wb_dat_o <= {26'h0, flags_q};
				`UCF_OFS_STATE: wb_dat_o <= {22'h0, tx_started_q, tx_busy, last_hdr_q};
				default: wb_dat_o <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	rx_quiet_tx_a: assert property (tx_busy |-> !rxb_v_q) else $error("byte taken while sending");
	flush_flags_a: assert property (flush_p |=> flags_q[`UCF_FL_FLUSH] && flags_q[`UCF_FL_STOP])
		else $error("break flags not set");
	flush_restart_a: assert property (flush_any |=> frm_st == F_HDR && rx_st == RX_WAIT_HIGH)
		else $error("receiver not reset by break");
	break_len_a: assert property (flush_p |-> !rx_i && low_q > 11'(`UCF_BYTE_CYC))
		else $error("break shorter than a byte");
	wake_active_a: assert property (wake_ping_i && !sleep_i |=> flags_q[`UCF_FL_STOP] && flags_q[`UCF_FL_FLUSH])
		else $error("active wake flags missing");
	resp_discard_a: assert property (flush_any && tx_busy |=> !tx_busy && tx_o && rsp_abort_o)
		else $error("response not discarded");
	tx_after_read_a: assert property ($rose(tx_busy) |-> cmd_valid_o && cmd_o.is_read)
		else $error("sending without read");
	stack_gate_a: assert property (cmd_valid_o && cmd_o.req inside {ucf_pkg::UCF_STK_RD, ucf_pkg::UCF_STK_WR}
		|-> ctrl_q[`UCF_CTRL_STACK]) else $error("stack command acted without role");
	reserved_nop_a: assert property (good && rsvd |=> !cmd_valid_o && flags_q[`UCF_FL_INVAL])
		else $error("reserved request acted");
	bad_check_a: assert property (last_b && !good |=> !cmd_valid_o) else $error("bad frame acted");
	wb_answer_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer timing");

endmodule

// >>> include/ucf_params.svh
// Constants of the host-port command frame engine
`ifndef UCF_PARAMS_SVH
`define UCF_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define UCF_CLK_HZ 100000000
`define UCF_BAUD_BPS 1000000
`define UCF_BIT_CYC (`UCF_CLK_HZ / `UCF_BAUD_BPS)
`define UCF_HALF_CYC (`UCF_BIT_CYC / 2)
`define UCF_BYTE_BITS 10
`define UCF_BYTE_CYC (`UCF_BYTE_BITS * `UCF_BIT_CYC)
`define UCF_BRK_BITS 11
`define UCF_BRK_CYC (`UCF_BRK_BITS * `UCF_BIT_CYC)
`define UCF_CNT_W 8
`define UCF_LOW_W 11

// ----------------------------------------
// Frame layout and check code
// ----------------------------------------
`define UCF_CRC_INIT 16'hffff
`define UCF_CRC_POLY 16'ha001
`define UCF_HDR_CMD_BIT 7
`define UCF_REQ_SRD 3'h0
`define UCF_REQ_SWR 3'h1
`define UCF_REQ_KRD 3'h2
`define UCF_REQ_KWR 3'h3
`define UCF_REQ_BRD 3'h4
`define UCF_REQ_BWR 3'h5
`define UCF_REQ_RWR 3'h6
`define UCF_REQ_RSV 3'h7

// ----------------------------------------
// Register map, fields and reset values
// ----------------------------------------
`define UCF_OFS_CTRL 8'h00
`define UCF_OFS_ADDR 8'h04
`define UCF_OFS_FLAGS 8'h08
`define UCF_OFS_STATE 8'h0c
`define UCF_CTRL_STACK 0
`define UCF_CTRL_DIR 1
`define UCF_ADDR_REV_LSB 8
`define UCF_FL_FLUSH 0
`define UCF_FL_STOP 1
`define UCF_FL_CRC 2
`define UCF_FL_INVAL 3
`define UCF_FL_TRWAIT 4
`define UCF_FL_TRSOFI 5
`define UCF_CTRL_RST 2'h0
`define UCF_NODE_RST 6'h00
`define UCF_FLAGS_RST 6'h00

`endif

// >>> include/ucf_pkg.sv
// Types shared by the host-port command frame engine
`include "ucf_params.svh"

package ucf_pkg;

	// Request codes carried in header bits 6..4
	typedef enum logic [2:0] {
		UCF_SGL_RD = `UCF_REQ_SRD,
		UCF_SGL_WR = `UCF_REQ_SWR,
		UCF_STK_RD = `UCF_REQ_KRD,
		UCF_STK_WR = `UCF_REQ_KWR,
		UCF_BC_RD = `UCF_REQ_BRD,
		UCF_BC_WR = `UCF_REQ_BWR,
		UCF_BC_REV_WR = `UCF_REQ_RWR,
		UCF_RESERVED = `UCF_REQ_RSV
	} ucf_req_e;

	// One accepted command towards the register core
	typedef struct packed {
		ucf_req_e req;
		logic is_read;
		logic prop_dir;
		logic [15:0] reg_addr;
		logic [2:0] len_m1;
		logic [63:0] data;
	} ucf_cmd_s;

	// One response byte offered by the register core
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} ucf_rsp_s;

endpackage

// >>> tb/test_ucf_frame.sv
// Self-checking bench for the host-port frame engine
`timescale 1ns/10ps
module test_ucf_frame;
	logic clock_i, reset_i, rx, tx, sleep_i, wake_ping_i, cmd_valid, rsp_ready, rsp_abort;
	logic wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdat, wb_rdat;
	ucf_pkg::ucf_cmd_s cmd;
	ucf_pkg::ucf_rsp_s rsp;
	int mismatches, n_compared, n_cmd, n_abort;

	ucf_frame uut (.clock_i(clock_i), .reset_i(reset_i), .rx_i(rx), .tx_o(tx), .sleep_i(sleep_i),
		.wake_ping_i(wake_ping_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .rsp_i(rsp), .rsp_ready_o(rsp_ready),
		.rsp_abort_o(rsp_abort), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
	ucf_host_model host (.clock_i(clock_i), .rx_o(rx), .tx_i(tx));

	// 100 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// Count command and abort pulses; both stand a single cycle
	always @(posedge clock_i) begin
		if (cmd_valid === 1'b1) n_cmd++;
		if (rsp_abort === 1'b1) n_abort++;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Classic Wishbone cycle; only the watchdog ends a wait for a dead slave
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hf;
		wb_wdat <= dat;
		do begin
			@(posedge clock_i);
		end while (wb_ack !== 1'b1);
		rd = wb_rdat;
		chk("wb_ack", wb_ack, 32'h1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
		logic [31:0] d;
		wb(1'b0, adr, 32'h0, d);
		chk(what, d, exp);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] d;
		wb(1'b1, adr, dat, d);
	endtask

	// Reflected check code, worked out here independently of the design
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction

	// Whole command frame; bad spoils the check code on purpose
	task automatic frame(input logic [7:0] hdr, input logic [7:0] node, input logic bad);
		logic [7:0] q[$];
		logic [15:0] c;
		q.push_back(hdr);
		if (hdr[6:5] == 2'b00) q.push_back(node);
		q.push_back(8'h12);
		q.push_back(8'h34);
		for (int i = 0; i <= hdr[2:0]; i++) q.push_back(8'ha0 + 8'(i));
		c = crc16(q) ^ {15'h0, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) host.send_byte(q[i]);
		repeat (20) @(posedge clock_i);
	endtask

	task automatic cmd_case(input logic [7:0] hdr, input logic [7:0] node, input logic take, input logic pdir);
		int n0;
		n0 = n_cmd;
		frame(hdr, node, 1'b0);
		chk("cmd count", n_cmd - n0, {31'h0, take});
		if (take) begin
			chk("req", cmd.req, {29'h0, hdr[6:4]});
			chk("reg_addr", cmd.reg_addr, 32'h1234);
			chk("len_m1", cmd.len_m1, {29'h0, hdr[2:0]});
			chk("data0", cmd.data[7:0], 32'ha0);
			chk("prop_dir", cmd.prop_dir, {31'h0, pdir});
		end
	endtask

	// Response byte handed over once the sender is ready
	task automatic give(input logic [7:0] d, input logic last);
		int n;
		n = 0;
		rsp <= '{valid: 1'b1, last: last, data: d};
		do begin
			@(posedge clock_i);
			n++;
		end while (!(rsp_ready === 1'b1 && rsp.valid) && n < 50);
		chk("rsp ready", rsp_ready, 32'h1);
		rsp <= '0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_route();
		cmd_case(8'h90, 8'h00, 1'b1, 1'b0);
		cmd_case(8'h90, 8'h05, 1'b0, 1'b0);
		wr(8'h04, 32'h0500);
		wr(8'h00, 32'h2);
		cmd_case(8'h98, 8'h05, 1'b1, 1'b1);
		cmd_case(8'hb0, 8'h00, 1'b0, 1'b1);
		wr(8'h00, 32'h3);
		cmd_case(8'hb8, 8'h00, 1'b1, 1'b1);
		cmd_case(8'hd1, 8'h00, 1'b1, 1'b1);
		cmd_case(8'he0, 8'h00, 1'b1, 1'b0);
		chk("rev write is_read", cmd.is_read, 32'h0);
		cmd_case(8'hf0, 8'h00, 1'b0, 1'b0);
		rdchk(8'h08, 32'h08, "invalid flag");
		wr(8'h08, 32'h3f);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h0);
		$display("test route done");
	endtask

	task automatic t_flush();
		int n0;
		n0 = n_cmd;
		frame(8'h90, 8'h00, 1'b1);
		chk("bad frame", n_cmd - n0, 32'h0);
		rdchk(8'h08, 32'h04, "check flag");
		wr(8'h08, 32'h3f);
		host.send_byte(8'h90);
		host.flush();
		rdchk(8'h08, 32'h03, "flush flags");
		wr(8'h08, 32'h3f);
		cmd_case(8'h90, 8'h00, 1'b1, 1'b0);
		sleep_i <= 1'b1;
		wake_ping_i <= 1'b1;
		@(posedge clock_i);
		wake_ping_i <= 1'b0;
		sleep_i <= 1'b0;
		rdchk(8'h08, 32'h01, "wake from sleep");
		wr(8'h08, 32'h3f);
		wake_ping_i <= 1'b1;
		@(posedge clock_i);
		wake_ping_i <= 1'b0;
		rdchk(8'h08, 32'h03, "wake when active");
		wr(8'h08, 32'h3f);
		$display("test flush done");
	endtask

	task automatic t_resp();
		int n0;
		chk("no unasked reply", host.got_q.size(), 32'h0);
		cmd_case(8'hc0, 8'h00, 1'b1, 1'b0);
		chk("is_read", cmd.is_read, 32'h1);
		rdchk(8'h0c, 32'h1c0, "state waiting");
		give(8'h5a, 1'b1);
		repeat (1100) @(posedge clock_i);
		chk("reply count", host.got_q.size(), 32'h1);
		chk("reply byte", host.got_q[0], 32'h5a);
		cmd_case(8'h80, 8'h00, 1'b1, 1'b0);
		give(8'hc3, 1'b0);
		n0 = n_cmd;
		host.send_byte(8'h90);
		chk("rx while sending", n_cmd - n0, 32'h0);
		n0 = n_abort;
		host.flush();
		chk("abort pulse", n_abort - n0, 32'h1);
		rdchk(8'h08, 32'h23, "flush in reply");
		wr(8'h08, 32'h3f);
		cmd_case(8'h80, 8'h00, 1'b1, 1'b0);
		n0 = n_abort;
		host.flush();
		chk("abort before reply", n_abort - n0, 32'h1);
		chk("ready after break", rsp_ready, 32'h0);
		rdchk(8'h08, 32'h13, "flush before reply");
		wr(8'h08, 32'h3f);
		$display("test response done");
	endtask

	// Main sequence
	initial begin
		reset_i = 1'b1;
		sleep_i = 1'b0;
		wake_ping_i = 1'b0;
		rsp = '0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_wdat = 32'h0;
		repeat (12) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
		rdchk(8'h00, 32'h0, "ctrl reset");
		rdchk(8'h04, 32'h0, "addr reset");
		rdchk(8'h08, 32'h0, "flags reset");
		wr(8'h40, 32'hffff);
		rdchk(8'h40, 32'h0, "unmapped");
		$display("test registers done");
		t_route();
		t_flush();
		t_resp();
		finish_test();
	end

	// Watchdog: the run needs about 95k cycles
	initial begin
		#1000000;
		mismatches++;
		$display("[ERR] watchdog expired");
		finish_test();
	end
endmodule

// >>> tb/ucf_host_model.sv
// Host microcontroller model on the half-duplex UART pins
`timescale 1ns/10ps
module ucf_host_model #(
	parameter int BIT_CYC = 100,
	parameter int BRK_CYC = 1150,
	parameter int MAX_BRK_CYC = 2000,
	parameter int GAP_CYC = 300
) (
	// Clock
	input wire logic clock_i,
	// UART pins seen from the host
	output logic rx_o,
	input wire logic tx_i
);
	logic [7:0] got_q[$];

	// Line idles high, as its pull-up leaves it
	initial rx_o = 1'b1;

	// One byte: start bit, data LSB first, one stop bit
	task automatic send_byte(input logic [7:0] b);
		rx_o <= 1'b0;
		repeat (BIT_CYC) @(posedge clock_i);
		for (int i = 0; i < 8; i++) begin
			rx_o <= b[i];
			repeat (BIT_CYC) @(posedge clock_i);
		end
		rx_o <= 1'b1;
		repeat (BIT_CYC) @(posedge clock_i);
	endtask

	// Flush break, kept short of the limit, then the quiet time before a frame
	task automatic flush();
		rx_o <= 1'b0;
		repeat ((BRK_CYC < MAX_BRK_CYC) ? BRK_CYC : MAX_BRK_CYC) @(posedge clock_i);
		rx_o <= 1'b1;
		repeat (GAP_CYC) @(posedge clock_i);
	endtask

	// Collect response bytes, sampled in mid-bit
	initial forever begin
		logic [7:0] b;
		@(negedge tx_i);
		repeat (BIT_CYC + BIT_CYC / 2) @(posedge clock_i);
		for (int i = 0; i < 8; i++) begin
			b[i] = tx_i;
			repeat (BIT_CYC) @(posedge clock_i);
		end
		got_q.push_back(b);
	end
endmodule
